/* File: core/tvc_pkg.sv */
/*
  tvc_pkg: register map, field positions, reset values, bus and state
  types of the 8-bit compare timer.
  Assumes an AXI4-Lite master with 32-bit data and 8-bit addresses.
*/
package tvc_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_CNT  = 8'h00;
  localparam logic [7:0] OFS_CORA = 8'h04;
  localparam logic [7:0] OFS_CORB = 8'h08;
  localparam logic [7:0] OFS_CR0  = 8'h0c;
  localparam logic [7:0] OFS_CR1  = 8'h10;
  localparam logic [7:0] OFS_CSR  = 8'h14;

  // register index from address bits 4:2, none for unmapped
  localparam logic [2:0] IDX_CNT  = 3'h0;
  localparam logic [2:0] IDX_CORA = 3'h1;
  localparam logic [2:0] IDX_CORB = 3'h2;
  localparam logic [2:0] IDX_CR0  = 3'h3;
  localparam logic [2:0] IDX_CR1  = 3'h4;
  localparam logic [2:0] IDX_CSR  = 3'h5;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // field positions
  localparam int CR0_CMIEB = 7;
  localparam int CR0_CMIEA = 6;
  localparam int CR0_OVIE  = 5;
  localparam int CR1_TRIGGER_ENABLE  = 2;
  localparam int CR1_ICKS  = 0;
  localparam int CSR_CMFB  = 7;
  localparam int CSR_CMFA  = 6;
  localparam int CSR_OVF   = 5;

  // reset values and masks
  localparam logic [7:0] CNT_RST     = 8'h00;
  localparam logic [7:0] COR_RST     = 8'hff;
  localparam logic [7:0] CR_RST      = 8'h00;
  localparam logic [7:0] CR1_RW_MASK = 8'h1d;
  localparam logic [7:0] CR1_ONES    = 8'he2;
  localparam logic [7:0] CNT_MAX     = 8'hff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN_HALT = 2'b01,
    RUN_GO   = 2'b10
  } tvc_run_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tvc_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tvc_axil_rsp_t;

endpackage

/* File: core/tvc_timer.sv */
/*
  tvc_timer: 8-bit up-counter with two compare registers, waveform
  output, trigger start and pin clear, behind an AXI4-Lite slave.
  Assumes pins are asynchronous to sys_clk; the clear pin pulse is
  held long enough to be seen by a two-stage synchroniser.
*/
`timescale 1ns/100ps
module tvc_timer (
  input  logic                   sys_clk,
  input  logic                   rst,
  input  logic                   ce,
  input  tvc_pkg::tvc_axil_req_t bus_in,
  output tvc_pkg::tvc_axil_rsp_t bus_out,
  input  logic                   trigger_pin,
  input  logic                   clear_pin,
  input  logic                   count_clk_pin,
  output logic                   wave_out_pin,
  output logic                   irq_req
);
  import tvc_pkg::*;

  typedef struct packed {
    tvc_axil_rsp_t rsp;
    logic [7:0]    awaddr;
    logic [7:0]    wdata;
    logic          wstrb0;
  } tvc_bus_t;

  typedef struct packed {
    logic [7:0] up_counter;
    logic [7:0] compare_reg_a;
    logic [7:0] compare_reg_b;
    logic [7:0] control_reg_zero;
    logic [7:0] control_reg_one;
    logic [3:0] out_sel;
    logic       overflow_flag;
    logic       match_a_flag;
    logic       match_b_flag;
    logic [7:0] psc;
    logic       src_prev;
    logic [2:0] pin_prev;
    tvc_run_t   run;
    logic       wave;
    logic       irq;
  } tvc_tmr_t;

  tvc_bus_t   b;
  tvc_bus_t   next_b;
  tvc_tmr_t   t;
  tvc_tmr_t   next_t;
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic       wr_fire;
  logic       wr_cnt;
  logic       wr_cora;
  logic       wr_corb;
  logic       wr_cr0;
  logic       wr_cr1;
  logic       wr_csr;
  logic       src;
  logic       both;
  logic       tick;
  logic       trg_edge;
  logic       trigger_enable;
  logic       running;
  logic       inc;
  logic       match_a;
  logic       match_b;
  logic       clr;
  logic       ovf_set;
  logic [1:0] ccl;
  logic [2:0] cks;
  logic       act_tog;
  logic       act_one;
  logic       act_zero;
  logic [7:0] rd_val;

  // address decode shared by read and write paths
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    if (a[7:5] != 3'h0 || a[4:2] > IDX_CSR) begin
      return IDX_NONE;
    end
    return a[4:2];
  endfunction

  // pin synchronisers: stage one feeds stage two only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else if (ce) begin
      pin_s1 <= {count_clk_pin, clear_pin, trigger_pin};
      pin_s2 <= pin_s1;
    end
  end

  // write commit cycle: both halves held, no response pending
  assign wr_fire = ~b.rsp.awready & ~b.rsp.wready & ~b.rsp.bvalid;
  assign widx    = reg_idx(b.awaddr);
  assign ridx    = reg_idx(bus_in.araddr);
  assign wr_cnt  = wr_fire & b.wstrb0 & (widx == IDX_CNT);
  assign wr_cora = wr_fire & b.wstrb0 & (widx == IDX_CORA);
  assign wr_corb = wr_fire & b.wstrb0 & (widx == IDX_CORB);
  assign wr_cr0  = wr_fire & b.wstrb0 & (widx == IDX_CR0);
  assign wr_cr1  = wr_fire & b.wstrb0 & (widx == IDX_CR1);
  assign wr_csr  = wr_fire & b.wstrb0 & (widx == IDX_CSR);

  // read mux, reserved bits of control_reg_one read as one
  always_comb begin
    case (ridx)
      IDX_CNT:  rd_val = t.up_counter;
      IDX_CORA: rd_val = t.compare_reg_a;
      IDX_CORB: rd_val = t.compare_reg_b;
      IDX_CR0:  rd_val = t.control_reg_zero;
      IDX_CR1:  rd_val = t.control_reg_one | CR1_ONES;
      IDX_CSR:  rd_val = {t.match_b_flag, t.match_a_flag, t.overflow_flag, 1'b0, t.out_sel};
      default:  rd_val = 8'h00;
    endcase
  end

  // axi4-lite slave: aw and w latched independently
  always_comb begin
    next_b = b;
    if (b.rsp.awready && bus_in.awvalid) begin
      next_b.rsp.awready = 1'b0;
      next_b.awaddr      = bus_in.awaddr;
    end
    if (b.rsp.wready && bus_in.wvalid) begin
      next_b.rsp.wready = 1'b0;
      next_b.wdata      = bus_in.wdata[7:0];
      next_b.wstrb0     = bus_in.wstrb[0];
    end
    if (b.rsp.bvalid && bus_in.bready) begin
      next_b.rsp.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_b.rsp.awready = 1'b1;
      next_b.rsp.wready  = 1'b1;
      next_b.rsp.bvalid  = 1'b1;
      next_b.rsp.bresp   = (widx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (b.rsp.rvalid && bus_in.rready) begin
      next_b.rsp.rvalid  = 1'b0;
      next_b.rsp.arready = 1'b1;
    end
    if (b.rsp.arready && bus_in.arvalid) begin
      next_b.rsp.arready = 1'b0;
      next_b.rsp.rvalid  = 1'b1;
      next_b.rsp.rdata   = {24'h000000, rd_val};
      next_b.rsp.rresp   = (ridx == IDX_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // count source: one level muxed from taps and the pin
  always_comb begin
    cks  = t.control_reg_zero[2:0];
    both = (cks == 3'b111);
    src  = 1'b0;
    if (cks[2]) begin
      case (cks[1:0])
        2'b01:   src = ~pin_s2[2];
        2'b10:   src = pin_s2[2];
        default: src = 1'b0;
      endcase
    end else if (cks != 3'b000) begin
      src = t.psc[{cks[1:0], t.control_reg_one[CR1_ICKS]}];
    end
  end

  // any high-to-low step of the muxed level counts, a select change too; select 111 counts both pin edges instead
  assign tick = both ? (pin_s2[2] ^ t.pin_prev[2]) : (t.src_prev & ~src);

  // trigger edge decode
  always_comb begin
    case (t.control_reg_one[4:3])
      2'b01:   trg_edge = pin_s2[0] & ~t.pin_prev[0];
      2'b10:   trg_edge = ~pin_s2[0] & t.pin_prev[0];
      2'b11:   trg_edge = pin_s2[0] ^ t.pin_prev[0];
      default: trg_edge = 1'b0;
    endcase
  end

  assign trigger_enable    = t.control_reg_one[CR1_TRIGGER_ENABLE];
  assign running = ~trigger_enable | (t.run == RUN_GO);
  assign inc     = tick & running;
  assign ccl     = t.control_reg_zero[4:3];
  // match is dropped when its own compare register is being written
  assign match_a = inc & (t.up_counter == t.compare_reg_a) & ~wr_cora;
  assign match_b = inc & (t.up_counter == t.compare_reg_b) & ~wr_corb;
  assign clr     = ((ccl == 2'b01) & match_a)
                 | ((ccl == 2'b10) & match_b)
                 | ((ccl == 2'b11) & pin_s2[1] & ~t.pin_prev[1]);
  assign ovf_set = inc & (t.up_counter == CNT_MAX) & ~clr & ~wr_cnt;

  // output actions of both matches merged by priority
  assign act_tog  = (match_a & (t.out_sel[1:0] == 2'b11)) | (match_b & (t.out_sel[3:2] == 2'b11));
  assign act_one  = (match_a & (t.out_sel[1:0] == 2'b10)) | (match_b & (t.out_sel[3:2] == 2'b10));
  assign act_zero = (match_a & (t.out_sel[1:0] == 2'b01)) | (match_b & (t.out_sel[3:2] == 2'b01));

  // timer next state
  always_comb begin
    next_t          = t;
    next_t.psc      = t.psc + 8'h01;
    next_t.src_prev = src;
    next_t.pin_prev = pin_s2;
    // clear first, then a write, then the count
    if (clr) begin
      next_t.up_counter = CNT_RST;
    end else if (wr_cnt) begin
      next_t.up_counter = b.wdata;
    end else if (inc) begin
      next_t.up_counter = t.up_counter + 8'h01;
    end
    if (wr_cora) begin
      next_t.compare_reg_a = b.wdata;
    end
    if (wr_corb) begin
      next_t.compare_reg_b = b.wdata;
    end
    if (wr_cr0) begin
      next_t.control_reg_zero = b.wdata;
    end
    if (wr_cr1) begin
      next_t.control_reg_one = b.wdata & CR1_RW_MASK;
    end
    // flags clear on written zero; a set in the same cycle wins
    if (wr_csr) begin
      next_t.out_sel       = b.wdata[3:0];
      next_t.overflow_flag = t.overflow_flag & b.wdata[CSR_OVF];
      next_t.match_a_flag  = t.match_a_flag & b.wdata[CSR_CMFA];
      next_t.match_b_flag  = t.match_b_flag & b.wdata[CSR_CMFB];
    end
    next_t.overflow_flag = next_t.overflow_flag | ovf_set;
    next_t.match_a_flag  = next_t.match_a_flag | match_a;
    next_t.match_b_flag  = next_t.match_b_flag | match_b;
    // trigger mode: a clear parks the counter, an edge restarts it
    case (t.run)
      RUN_HALT: begin
        if (trg_edge) begin
          next_t.run = RUN_GO;
        end
      end
      RUN_GO: begin
        if (trigger_enable && clr) begin
          next_t.run = RUN_HALT;
        end
      end
      default: next_t.run = RUN_HALT;
    endcase
    if (act_tog) begin
      next_t.wave = ~t.wave;
    end else if (act_one) begin
      next_t.wave = 1'b1;
    end else if (act_zero) begin
      next_t.wave = 1'b0;
    end
    next_t.irq = (next_t.overflow_flag & next_t.control_reg_zero[CR0_OVIE])
               | (next_t.match_a_flag & next_t.control_reg_zero[CR0_CMIEA])
               | (next_t.match_b_flag & next_t.control_reg_zero[CR0_CMIEB]);
  end

  // state registers, frozen while ce is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      b.rsp.awready      <= 1'b1;
      b.rsp.wready       <= 1'b1;
      b.rsp.bvalid       <= 1'b0;
      b.rsp.bresp        <= RESP_OKAY;
      b.rsp.arready      <= 1'b1;
      b.rsp.rvalid       <= 1'b0;
      b.rsp.rdata        <= 32'h00000000;
      b.rsp.rresp        <= RESP_OKAY;
      b.awaddr           <= 8'h00;
      b.wdata            <= 8'h00;
      b.wstrb0           <= 1'b0;
      t.up_counter       <= CNT_RST;
      t.compare_reg_a    <= COR_RST;
      t.compare_reg_b    <= COR_RST;
      t.control_reg_zero <= CR_RST;
      t.control_reg_one  <= CR_RST;
      t.out_sel          <= 4'h0;
      t.overflow_flag    <= 1'b0;
      t.match_a_flag     <= 1'b0;
      t.match_b_flag     <= 1'b0;
      t.psc              <= 8'h00;
      t.src_prev         <= 1'b0;
      t.pin_prev         <= 3'h0;
      t.run              <= RUN_HALT;
      t.wave             <= 1'b0;
      t.irq              <= 1'b0;
    end else if (ce) begin
      b <= next_b;
      t <= next_t;
    end
  end

  assign bus_out      = b.rsp;
  assign wave_out_pin = t.wave;
  assign irq_req      = t.irq;

  // checks on the counter, flags, waveform, trigger and bus response
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  wave_after_reset_a: assert property ($past(rst) |-> !wave_out_pin)
    else $error("wave not low after reset");
  clear_beats_write_a: assert property (ce && wr_cnt && clr |=> t.up_counter == 8'h00)
    else $error("counter write beat clear");
  write_beats_count_a: assert property (ce && wr_cnt && !clr && inc |=> t.up_counter == $past(b.wdata))
    else $error("count beat counter write");
  match_inhibit_a: assert property (ce && wr_cora && inc && ccl == 2'b01 && !wr_cnt
                                    |=> t.up_counter == $past(t.up_counter) + 8'h01)
    else $error("match not suppressed on compare write");
  toggle_prio_a: assert property (ce && match_a && match_b && (t.out_sel[1:0] == 2'b11 || t.out_sel[3:2] == 2'b11)
                                  |=> wave_out_pin != $past(wave_out_pin))
    else $error("toggle lost priority");
  falling_inc_a: assert property (ce && running && !both && t.src_prev && !src && !clr && !wr_cnt
                                  |=> t.up_counter == $past(t.up_counter) + 8'h01)
    else $error("no count on falling tap");
  overflow_set_a: assert property (ce && ovf_set |=> t.overflow_flag ##1 1'b1)
    else $error("overflow flag not set");
  irq_gate_a: assert property (!t.control_reg_zero[CR0_OVIE] && !t.control_reg_zero[CR0_CMIEA]
                               && !t.control_reg_zero[CR0_CMIEB] && $stable(t.control_reg_zero) |-> !irq_req)
    else $error("request raised while disabled");
  trig_off_a: assert property (t.control_reg_one[4:3] == 2'b00 |-> !trg_edge)
    else $error("trigger seen while disabled");
  halt_on_clear_a: assert property (ce && trigger_enable && clr && !trg_edge && t.run == RUN_GO
                                    |=> t.run == RUN_HALT && t.up_counter == 8'h00)
    else $error("trigger mode did not halt");
  pin_clear_a: assert property (ce && ccl == 2'b11 && pin_s2[1] && !t.pin_prev[1] |=> t.up_counter == 8'h00)
    else $error("clear pin ignored");
  pwm_period_a: assert property (ce && ccl == 2'b01 && match_a && t.out_sel == 4'b0110
                                 |=> t.up_counter == 8'h00 && wave_out_pin)
    else $error("free pwm period wrong");
  bresp_hold_a: assert property (bus_out.bvalid && !bus_in.bready |=> bus_out.bvalid)
    else $error("bvalid dropped early");

  pwm_rise_c: cover property (ce && match_a ##1 wave_out_pin);
  overflow_c: cover property (ce && ovf_set);
  trig_resume_c: cover property (t.run == RUN_HALT ##1 t.run == RUN_GO);
  pulse_fall_c: cover property (ce && ccl == 2'b10 && match_b ##1 !wave_out_pin);
endmodule

/* File: bench/tvc_pins.sv */
/*
  tvc_pins: model of the pins around the timer (trigger, clear, count clock).
  Assumes the bench calls its tasks; pins change just after sys_clk rises.
*/
`timescale 1ns/100ps
module tvc_pins (
  input  logic sys_clk,
  output logic trigger_pin,
  output logic clear_pin,
  output logic count_clk_pin
);
  // idle levels; the count clock stands still outside bursts
  initial begin
    trigger_pin   = 1'b0;
    clear_pin     = 1'b0;
    count_clk_pin = 1'b0;
  end
  // trigger level step
  task automatic trig(input logic lvl);
    @(posedge sys_clk);
    trigger_pin <= lvl;
  endtask
  // held 3 clocks: past the minimum and safe for the 2-stage sync
  task automatic clr_pulse();
    @(posedge sys_clk);
    clear_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    clear_pin <= 1'b0;
  endtask
  // n rising edges, 4 clocks per phase so each one is sampled
  task automatic ext_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk);
      count_clk_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      count_clk_pin <= 1'b0;
    end
  endtask
endmodule

/* File: bench/test_tvc_timer.sv */
/*
  test_tvc_timer: self-checking bench for the compare timer.
  Assumes the pin model tvc_pins and the /8 internal tap for clock select 001.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module test_tvc_timer;
  import tvc_pkg::*;
  logic          sys_clk;
  logic          rst;
  tvc_axil_req_t req;
  tvc_axil_rsp_t rsp;
  logic          trigger_pin;
  logic          clear_pin;
  logic          count_clk_pin;
  logic          wave_out_pin;
  logic          irq_req;
  int            n_mismatch;
  int            checks;
  logic [7:0]    d;
  logic [1:0]    r;

  tvc_timer u_dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .bus_in(req), .bus_out(rsp),
    .trigger_pin(trigger_pin), .clear_pin(clear_pin), .count_clk_pin(count_clk_pin),
    .wave_out_pin(wave_out_pin), .irq_req(irq_req));
  tvc_pins u_pins (.sys_clk(sys_clk), .trigger_pin(trigger_pin), .clear_pin(clear_pin),
    .count_clk_pin(count_clk_pin));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: all scenarios need little more than a thousand cycles
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge sys_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, v};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (rsp.awready && !aw_ok) begin
        aw_ok = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (rsp.wready && !w_ok) begin
        w_ok = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // read: held until taken, rready held until the answer
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(posedge sys_clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    while (rsp.rvalid !== 1'b1) @(posedge sys_clk);
    d = rsp.rdata[7:0];
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // cycles until the wave output shows lvl
  task automatic wait_lvl(input logic lvl, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      c++;
    end while (wave_out_pin !== lvl && c < 600);
    // a level that never comes is a failure, not a silent return
    if (wave_out_pin !== lvl) begin
      n_mismatch++;
      $display("mismatch t=%0t wave level not reached", $time);
    end
  endtask

  task automatic t_reset();
    `CHK(wave_out_pin, 1'b0)
    rd(OFS_CORA);
    `CHK(d, COR_RST)
    rd(OFS_CR1);
    `CHK(d, CR1_ONES)
    rd(OFS_CNT);
    `CHK(d, CNT_RST)
    rd(8'h1c);
    `CHK(r, RESP_SLVERR)
  endtask

  // A=3 clears, high at A, low at B=1, /8 tap: period 32, high 16
  task automatic t_pwm();
    int c;
    int h;
    wr(OFS_CORA, 8'h03);
    wr(OFS_CORB, 8'h01);
    wr(OFS_CSR, 8'h06);
    wr(OFS_CR0, 8'h09);
    wait_lvl(1'b1, c);
    wait_lvl(1'b0, h);
    wait_lvl(1'b1, c);
    `CHK(h, 16)
    `CHK(h + c, 32)
    wr(OFS_CR0, 8'h00);
  endtask

  // A and B equal: toggle beats high beats low
  task automatic t_prio();
    logic [7:0] sel [3] = '{8'h07, 8'h0e, 8'h06};
    logic       prev;
    int         n;
    wr(OFS_CORB, 8'h03);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CSR, sel[i]);
      wr(OFS_CR0, 8'h09);
      repeat (80) @(posedge sys_clk);
      n = 0;
      prev = wave_out_pin;
      repeat (100) begin
        @(posedge sys_clk);
        if (wave_out_pin !== prev) n++;
        prev = wave_out_pin;
      end
      `CHK(n > 0, i < 2)
      `CHK(wave_out_pin | (i < 2), 1'b1)
      wr(OFS_CR0, 8'h00);
    end
  endtask

  // rollover sets the flag; request follows the enable
  task automatic t_ovf();
    wr(OFS_CSR, 8'h00);
    wr(OFS_CNT, 8'hfe);
    wr(OFS_CR0, 8'h01);
    repeat (40) @(posedge sys_clk);
    rd(OFS_CSR);
    `CHK(d[CSR_OVF], 1'b1)
    `CHK(irq_req, 1'b0)
    wr(OFS_CR0, 8'h21);
    repeat (3) @(posedge sys_clk);
    `CHK(irq_req, 1'b1)
    wr(OFS_CR0, 8'h00);
    wr(OFS_CSR, 8'h00);
    repeat (3) @(posedge sys_clk);
    `CHK(irq_req, 1'b0)
  endtask

  // B=5 clears, falling trigger starts a pulse of (B-A)*8
  task automatic t_trig();
    int c;
    int w;
    wr(OFS_CORA, 8'h02);
    wr(OFS_CORB, 8'h05);
    wr(OFS_CSR, 8'h06);
    wr(OFS_CR1, 8'h14);
    wr(OFS_CR0, 8'h11);
    repeat (100) @(posedge sys_clk);
    u_pins.trig(1'b1);
    repeat (40) @(posedge sys_clk);
    rd(OFS_CNT);
    `CHK(d, 8'h00)
    `CHK(wave_out_pin, 1'b0)
    u_pins.trig(1'b0);
    wait_lvl(1'b1, c);
    // 2-stage sync and restart, then 3 ticks of /8, tap phase unknown
    `CHK(c >= 21 && c <= 28, 1'b1)
    wait_lvl(1'b0, w);
    `CHK(w, 24)
    repeat (40) @(posedge sys_clk);
    rd(OFS_CNT);
    `CHK(d, 8'h00)
    wr(OFS_CR0, 8'h00);
    wr(OFS_CR1, 8'h00);
  endtask

  // clear pin rise clears a running counter
  task automatic t_clr();
    wr(OFS_CORA, 8'hff);
    wr(OFS_CORB, 8'hff);
    wr(OFS_CNT, 8'h80);
    wr(OFS_CR0, 8'h19);
    u_pins.clr_pulse();
    repeat (4) @(posedge sys_clk);
    rd(OFS_CNT);
    `CHK(d < 8'h02, 1'b1)
    wr(OFS_CR0, 8'h00);
  endtask

  // rising external edges; written after the switch so a spurious count is gone
  task automatic t_ext();
    wr(OFS_CR0, 8'h05);
    repeat (8) @(posedge sys_clk);
    wr(OFS_CNT, 8'h00);
    u_pins.ext_edges(4);
    repeat (6) @(posedge sys_clk);
    rd(OFS_CNT);
    `CHK(d, 8'h04)
    wr(OFS_CR0, 8'h00);
  endtask

  initial begin
    n_mismatch = 0;
    checks     = 0;
    req        = '0;
    rst        = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    // trigger first: needs the counter and wave still at their reset values
    t_trig();
    t_pwm();
    t_prio();
    t_ovf();
    t_clr();
    t_ext();
    end_of_test();
  end
endmodule
